// >>> pkg/acl_pkg.sv
// Purpose: shared constants and types of the converter control logic
// Assumes: 16-bit register port, 10-bit converter core
// Notes:   addresses are full byte addresses on the plain register port

package acl_pkg;

  // ***************************************************
  // widths
  // ***************************************************
  localparam int ACL_ADDR_W   = 32;
  localparam int ACL_DATA_W   = 16;
  localparam int ACL_SAMPLE_W = 10;
  localparam int ACL_SEL_W    = 4;
  localparam int ACL_EV_W     = 2;

  // ***************************************************
  // register addresses
  // ***************************************************
  localparam logic [31:0] ACL_ADDR_CONTROL = 32'h5000_1500;
  localparam logic [31:0] ACL_ADDR_CLEAR   = 32'h5000_1508;
  localparam logic [31:0] ACL_ADDR_RESULT  = 32'h5000_150a;
  localparam logic [31:0] ACL_ADDR_STATUS  = 32'h5000_1510;
  localparam logic [31:0] ACL_ADDR_MASK    = 32'h5000_1512;

  // ***************************************************
  // control register fields
  // ***************************************************
  localparam int ACL_B_FORCE_ZERO = 15;
  localparam int ACL_B_REG_ON     = 14;
  localparam int ACL_B_CHOP       = 13;
  localparam int ACL_B_MIDSCALE   = 12;
  localparam int ACL_B_SE         = 11;
  localparam int ACL_B_SIGN       = 10;
  localparam int ACL_B_SEL_HI     = 9;
  localparam int ACL_B_SEL_LO     = 6;
  localparam int ACL_B_IRQ_MASK   = 5;
  localparam int ACL_B_DONE       = 4;
  localparam int ACL_B_START      = 1;
  localparam int ACL_B_ENABLE     = 0;
  // plain read/write bits; start and done belong to the hardware
  localparam logic [15:0] ACL_CTRL_RW_MASK = 16'hffe1;
  localparam logic [15:0] ACL_CTRL_RESET   = 16'h0000;

  // ***************************************************
  // event bits of status and mask
  // ***************************************************
  localparam int ACL_EV_DONE    = 0;
  localparam int ACL_EV_IGNORED = 1;

  // ***************************************************
  // input selection codes
  // ***************************************************
  localparam logic [3:0] ACL_SEL_DIFF_PAIR01 = 4'h0;

  typedef enum logic [3:0] {
    ACL_CH_P0_0     = 4'h0,
    ACL_CH_P0_1     = 4'h1,
    ACL_CH_P0_2     = 4'h2,
    ACL_CH_P0_3     = 4'h3,
    ACL_CH_AGND     = 4'h4,
    ACL_CH_REF      = 4'h5,
    ACL_CH_RETAIN   = 4'h6,
    ACL_CH_BATT_HI  = 4'h7,
    ACL_CH_CONV_OUT = 4'h8,
    ACL_CH_BATT_LO  = 4'h9,
    ACL_CH_MIDSCALE = 4'he,
    ACL_CH_NONE     = 4'hf
  } acl_chan_t;

  typedef enum logic [1:0] {
    ACL_ST_IDLE   = 2'b00,
    ACL_ST_FIRST  = 2'b01,
    ACL_ST_SECOND = 2'b10
  } acl_state_t;

endpackage

// >>> pkg/acl_route_if.sv
// Purpose: carrier between control core and input router
// Assumes: one clock domain
// Notes:   router registers its channel outputs

`timescale 1ns/1ns

interface acl_route_if;
  import acl_pkg::*;
  logic [3:0] sel;
  logic       single_ended;
  logic       midscale;
  logic       sign;
  acl_chan_t  pos;
  acl_chan_t  neg;

  modport ctl (output sel, single_ended, midscale, sign,
               input  pos, neg);
  modport rt  (input  sel, single_ended, midscale, sign,
               output pos, neg);
endinterface

// >>> core/acl_route.sv
// Purpose: maps selection code and mode onto converter input channels
// Assumes: selection stable before a conversion starts
// Notes:   outputs registered; reserved codes connect nothing

`timescale 1ns/1ns

module acl_route
  import acl_pkg::*;
(
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_clk_en,
  // selection in, channels out
  acl_route_if.rt   rt
);

  typedef struct packed {
    acl_chan_t pos;
    acl_chan_t neg;
  } acl_rt_state_t;

  acl_rt_state_t s;
  acl_rt_state_t next_s;
  acl_chan_t     p;
  acl_chan_t     q;

  // channel decode, then polarity swap
  always_comb begin
    p = ACL_CH_NONE;
    q = ACL_CH_NONE;
    if (rt.single_ended) begin
      // codes above the last rail are reserved
      if (rt.sel <= ACL_CH_BATT_LO) begin
        p = acl_chan_t'(rt.sel); // [RQ7]
      end
      q = ACL_CH_NONE;
    end else if (rt.sel == ACL_SEL_DIFF_PAIR01) begin
      p = ACL_CH_P0_0; // [RQ8]
      q = ACL_CH_P0_1;
    end else begin
      p = ACL_CH_P0_2; // [RQ8]
      q = ACL_CH_P0_3;
    end
    // mute replaces the chosen input by mid-scale
    if (rt.midscale) begin
      p = ACL_CH_MIDSCALE; // [RQ3]
      q = ACL_CH_MIDSCALE;
    end
    next_s.pos = rt.sign ? q : p; // [RQ5]
    next_s.neg = rt.sign ? p : q;
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s <= '{pos: ACL_CH_NONE, neg: ACL_CH_NONE};
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  assign rt.pos = s.pos;
  assign rt.neg = s.neg;

endmodule // acl_route

// >>> core/acl_top.sv
// Purpose: control logic of the general-purpose 10-bit converter
// Assumes: converter core signals done as a level, data stable with it
// Notes:   registers on a plain port, read data one cycle later
//
// Notes on behaviour
// RQ1: force-zero and regulator-on bits, both reset clear
// RQ2: chopping takes two samples, opposite sign
// RQ3: mute samples mid-scale instead of input
// RQ4: input mode bit: 0 differential, 1 single-ended
// RQ5: sign bit inverts input and output polarity
// RQ6: software sets selection before setting start
// RQ7: single-ended codes route pins, rails, rest reserved
// RQ8: differential code 0 pins 0/1, else 2/3
// RQ9: done interrupt passes only while mask bit set
// RQ10: start begins conversion; completion clears it, sets done
// RQ11: done flag read-only, cleared by clear register write
// RQ12: enable low holds converter disabled and in reset
// RQ13: done line is flag AND mask, held level
//
// The strobed register port was decided locally.

`timescale 1ns/1ns

module acl_top
  import acl_pkg::*;
(
  // clock, reset, clock enable
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_reset,
  input  wire logic                    i_clk_en,
  // register port
  input  wire logic [ACL_ADDR_W-1:0]   i_addr,
  input  wire logic [ACL_DATA_W-1:0]   i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [ACL_DATA_W-1:0]   o_rdata,
  // regulator and converter control
  output logic                         o_regulator_force_zero,
  output logic                         o_regulator_on,
  output logic                         o_converter_enable,
  output logic                         o_converter_reset,
  output logic                         o_chopping_enable,
  output logic                         o_midscale_sample,
  output logic                         o_single_ended_select,
  output logic                         o_sign_inversion,
  output logic                         o_sample_start,
  output acl_chan_t                    o_pos_channel,
  output acl_chan_t                    o_neg_channel,
  // converter core answer
  input  wire logic                    i_sample_done,
  input  wire logic [ACL_SAMPLE_W-1:0] i_sample_data,
  // interrupts
  output logic                         o_done_irq,
  output logic                         o_irq
);

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic [ACL_DATA_W-1:0]   ctrl;
    acl_state_t              state;
    logic                    eff_sign;
    logic                    start_pulse;
    logic [ACL_SAMPLE_W-1:0] first;
    logic [ACL_SAMPLE_W-1:0] result;
    logic [ACL_EV_W-1:0]     status;
    logic [ACL_EV_W-1:0]     mask;
    logic [ACL_DATA_W-1:0]   rdata;
    logic                    done_meta;
    logic                    done_sync;
    logic                    done_prev;
    logic [ACL_SAMPLE_W-1:0] data_meta;
    logic [ACL_SAMPLE_W-1:0] data_sync;
  } acl_top_state_t;

  localparam acl_top_state_t ACL_TOP_RESET = '{
    ctrl:    ACL_CTRL_RESET,
    state:   ACL_ST_IDLE,
    default: '0
  };

  acl_top_state_t s;
  acl_top_state_t next_s;

  // ***************************************************
  // decode helpers
  // ***************************************************
  logic                    wr_ctrl;
  logic                    wr_clear;
  logic                    wr_status;
  logic                    wr_mask;
  logic                    done_edge;
  logic [ACL_SAMPLE_W-1:0] raw;
  logic [ACL_SAMPLE_W:0]   sum;

  // write decode; unmapped writes fall through and do nothing
  // full address match keeps neighbouring registers of the bus quiet
  assign wr_ctrl   = i_wr && (i_addr == ACL_ADDR_CONTROL);
  assign wr_clear  = i_wr && (i_addr == ACL_ADDR_CLEAR);
  assign wr_status = i_wr && (i_addr == ACL_ADDR_STATUS);
  assign wr_mask   = i_wr && (i_addr == ACL_ADDR_MASK);

  // only the synchronised copies are looked at, never the first stage
  // the core holds done high until its next start, so only a rise counts
  assign done_edge = s.done_sync && !s.done_prev;

  // output side of polarity inversion is done here in logic
  assign raw = s.eff_sign ? ~s.data_sync : s.data_sync; // [RQ5]

  // average of both chopped halves, offset cancels out
  // extra top bit keeps the carry of two full-scale halves
  assign sum = {1'b0, s.first} + {1'b0, raw}; // [RQ2]

  // ***************************************************
  // router instance
  // ***************************************************
  acl_route_if rif ();

  // selection and mode straight from the control register, sign from eff_sign
  assign rif.sel          = s.ctrl[ACL_B_SEL_HI:ACL_B_SEL_LO];
  assign rif.single_ended = s.ctrl[ACL_B_SE]; // [RQ4]
  assign rif.midscale     = s.ctrl[ACL_B_MIDSCALE];
  assign rif.sign         = s.eff_sign;

  acl_route u_route (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_clk_en  (i_clk_en),
    .rt        (rif.rt)
  );

  // ***************************************************
  // next-state logic
  // ***************************************************
  logic launch;
  logic go;
  logic finish;
  logic ignored;

  always_comb begin
    next_s      = s;
    launch      = 1'b0;
    go          = 1'b0;
    finish      = 1'b0;
    ignored     = 1'b0;
    next_s.start_pulse = 1'b0;

    // two-stage synchronisers for the core's answer
    next_s.done_meta = i_sample_done;
    next_s.done_sync = s.done_meta;
    next_s.done_prev = s.done_sync;
    next_s.data_meta = i_sample_data;
    next_s.data_sync = s.data_meta;

    // plain control bits; start and done kept by hardware
    if (wr_ctrl) begin
      next_s.ctrl = (i_wdata & ACL_CTRL_RW_MASK)
                  | (s.ctrl & ~ACL_CTRL_RW_MASK); // [RQ1] [RQ11]
      launch = i_wdata[ACL_B_START];
    end

    // a start is only taken while idle and enabled
    // a refused start is not queued; it only leaves a sticky event
    if (launch) begin
      if ((s.state == ACL_ST_IDLE) && next_s.ctrl[ACL_B_ENABLE]) begin
        go = 1'b1; // [RQ10]
      end else begin
        ignored = 1'b1;
      end
    end

    // conversion sequencer
    case (s.state)
      ACL_ST_IDLE: begin
        // sign follows the register between conversions
        next_s.eff_sign = next_s.ctrl[ACL_B_SIGN]; // [RQ5]
        if (go) begin
          next_s.state             = ACL_ST_FIRST;
          next_s.start_pulse       = 1'b1;
          next_s.ctrl[ACL_B_START] = 1'b1; // [RQ10]
        end
      end
      ACL_ST_FIRST: begin
        if (done_edge) begin
          if (s.ctrl[ACL_B_CHOP]) begin
            // second half with the opposite sign
            next_s.first       = raw; // [RQ2]
            next_s.eff_sign    = !s.eff_sign;
            next_s.start_pulse = 1'b1;
            next_s.state       = ACL_ST_SECOND;
          end else begin
            next_s.result = raw;
            finish        = 1'b1;
          end
        end
      end
      ACL_ST_SECOND: begin
        if (done_edge) begin
          next_s.result = sum[ACL_SAMPLE_W:1]; // [RQ2]
          finish        = 1'b1;
        end
      end
      default: begin
        next_s.state = ACL_ST_IDLE;
      end
    endcase

    // completion drops start and raises the done flag
    if (finish) begin
      next_s.state             = ACL_ST_IDLE;
      next_s.ctrl[ACL_B_START] = 1'b0; // [RQ10]
    end

    // disabled converter is held in reset, any run is abandoned
    // software must start again; a half-chopped result is never kept
    if (!next_s.ctrl[ACL_B_ENABLE]) begin
      next_s.state             = ACL_ST_IDLE; // [RQ12]
      next_s.ctrl[ACL_B_START] = 1'b0;
      next_s.start_pulse       = 1'b0;
      finish                   = 1'b0;
    end

    // done flag: any write to clear register, but a set wins
    if (finish) begin
      next_s.ctrl[ACL_B_DONE] = 1'b1; // [RQ10]
    end else if (wr_clear) begin
      next_s.ctrl[ACL_B_DONE] = 1'b0; // [RQ11]
    end

    // sticky events, write one to clear, set wins
    if (wr_status) begin
      next_s.status = s.status & ~i_wdata[ACL_EV_W-1:0];
    end
    if (finish) begin
      next_s.status[ACL_EV_DONE] = 1'b1;
    end
    if (ignored) begin
      next_s.status[ACL_EV_IGNORED] = 1'b1;
    end
    if (wr_mask) begin
      next_s.mask = i_wdata[ACL_EV_W-1:0];
    end

    // read data registered; unmapped and clear register read zero
    // reads have no side effects, so polling control is harmless
    next_s.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        ACL_ADDR_CONTROL: begin
          next_s.rdata = s.ctrl;
        end
        ACL_ADDR_RESULT: begin
          next_s.rdata[ACL_SAMPLE_W-1:0] = s.result;
        end
        ACL_ADDR_STATUS: begin
          next_s.rdata[ACL_EV_W-1:0] = s.status;
        end
        ACL_ADDR_MASK: begin
          next_s.rdata[ACL_EV_W-1:0] = s.mask;
        end
        default: begin
          next_s.rdata = '0;
        end
      endcase
    end
  end

  // ***************************************************
  // state register
  // ***************************************************
  // clock enable low freezes everything, synchronisers included
  // reset wins over the clock enable so a frozen block still clears
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s <= ACL_TOP_RESET;
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  // control pins straight from the register flops
  assign o_rdata                = s.rdata;
  assign o_regulator_force_zero = s.ctrl[ACL_B_FORCE_ZERO]; // [RQ1]
  assign o_regulator_on         = s.ctrl[ACL_B_REG_ON];     // [RQ1]
  assign o_converter_enable     = s.ctrl[ACL_B_ENABLE];     // [RQ12]
  assign o_converter_reset      = !s.ctrl[ACL_B_ENABLE];    // [RQ12]
  assign o_chopping_enable      = s.ctrl[ACL_B_CHOP];
  assign o_midscale_sample      = s.ctrl[ACL_B_MIDSCALE];   // [RQ3]
  assign o_single_ended_select  = s.ctrl[ACL_B_SE];         // [RQ4]
  assign o_sign_inversion       = s.eff_sign;               // [RQ5]
  assign o_sample_start         = s.start_pulse;
  assign o_pos_channel          = rif.pos;
  assign o_neg_channel          = rif.neg;

  // level toward the interrupt controller, held until the flag clears
  assign o_done_irq = s.ctrl[ACL_B_DONE]
                   && s.ctrl[ACL_B_IRQ_MASK]; // [RQ9] [RQ13]

  // summary interrupt of the sticky status bits
  assign o_irq = |(s.status & s.mask);

endmodule // acl_top

// >>> tb/acl_core_model.sv
// Purpose: behavioural converter core facing the control logic
// Assumes: one sample per start pulse, done held until next start
// Notes:   polarity swap at the input inverts the raw code

`timescale 1ns/1ns

module acl_core_model
  import acl_pkg::*;
#(
  parameter logic [ACL_SAMPLE_W-1:0] VALUE  = 10'h2a5,
  parameter logic [ACL_SAMPLE_W-1:0] OFFSET = 10'h004
)(
  // clock and reset
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_reset,
  // requests from the control logic
  input  wire logic                    i_start,
  input  wire logic                    i_sign,
  input  wire logic                    i_core_reset,
  input  wire logic [4:0]              i_delay,
  // answer
  output logic                         o_done,
  output logic      [ACL_SAMPLE_W-1:0] o_data
);
  logic [4:0] cnt;
  logic       busy;

  // ***************************************************
  // sample engine
  // ***************************************************
  // data is launched at start so it is stable long before done rises
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      busy   <= 1'b0;
      o_done <= 1'b0;
      cnt    <= 5'h00;
      o_data <= 10'h155;
    end else if (i_core_reset) begin // held in reset
      busy   <= 1'b0;
      o_done <= 1'b0;
      o_data <= ~o_data; // stale code, not a valid sample
    end else if (i_start) begin
      busy   <= 1'b1;
      o_done <= 1'b0;
      cnt    <= i_delay;
      // internal offset keeps its sign while the input swaps
      o_data <= i_sign ? ~(VALUE - OFFSET) : VALUE + OFFSET;
    end else if (busy && cnt == 5'h00) begin
      o_done <= 1'b1;
      busy   <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 5'h01;
    end
  end
endmodule // acl_core_model

// >>> tb/acl_top_sva.sv
// Purpose: port-level checks of the converter control logic
// Assumes: single clock domain, synchronous reset
// Notes:   channel outputs lag the settings by one cycle

`timescale 1ns/1ns

module acl_top_sva
  import acl_pkg::*;
(
  // clock, reset and write strobe
  input  wire logic      i_clk_sys,
  input  wire logic      i_reset,
  input  wire logic      i_wr,
  // watched outputs
  input  wire logic      o_regulator_force_zero,
  input  wire logic      o_regulator_on,
  input  wire logic      o_converter_enable,
  input  wire logic      o_converter_reset,
  input  wire logic      o_chopping_enable,
  input  wire logic      o_midscale_sample,
  input  wire logic      o_single_ended_select,
  input  wire logic      o_sign_inversion,
  input  wire logic      o_sample_start,
  input  wire acl_chan_t o_pos_channel,
  input  wire acl_chan_t o_neg_channel,
  input  wire logic      o_done_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  // ***************************************************
  // assertions
  // ***************************************************
  reset_clear_a: assert property ($fell(i_reset) |->
    !o_regulator_on && !o_regulator_force_zero && o_converter_reset)
    else $error("outputs not clear after reset");
  core_reset_a: assert property (
    o_converter_reset != o_converter_enable)
    else $error("core reset not inverse of enable");
  start_enable_a: assert property (
    o_sample_start |-> o_converter_enable)
    else $error("sample start while disabled");
  start_pulse_a: assert property (
    o_sample_start |=> !o_sample_start)
    else $error("sample start longer than one cycle");
  irq_hold_a: assert property (
    o_done_irq && !i_wr |=> o_done_irq)
    else $error("done interrupt dropped without a write");
  sign_change_a: assert property (
    $changed(o_sign_inversion) |-> $past(i_wr) || o_chopping_enable)
    else $error("sign changed without write or chopping");
  midscale_route_a: assert property (
    o_midscale_sample && $past(o_midscale_sample) |->
    o_pos_channel == ACL_CH_MIDSCALE && o_neg_channel == ACL_CH_MIDSCALE)
    else $error("mute does not route mid-scale");
  se_neg_a: assert property (
    o_single_ended_select && $past(o_single_ended_select) &&
    !(o_sign_inversion || $past(o_sign_inversion)) &&
    !(o_midscale_sample || $past(o_midscale_sample)) |->
    o_neg_channel == ACL_CH_NONE)
    else $error("single-ended negative input connected");
  diff_neg_a: assert property (
    !(o_single_ended_select || $past(o_single_ended_select)) &&
    !(o_sign_inversion || $past(o_sign_inversion)) &&
    !(o_midscale_sample || $past(o_midscale_sample)) &&
    !$past(i_reset) |-> o_neg_channel inside {ACL_CH_P0_1, ACL_CH_P0_3})
    else $error("differential negative input wrong");

  // main scenarios reached
  cover property (o_done_irq);
  cover property (o_sample_start && o_chopping_enable);
  cover property (o_midscale_sample && o_single_ended_select);
endmodule // acl_top_sva

// >>> tb/tb.sv
// Purpose: self-checking bench of the converter control logic
// Assumes: behavioural core model answers each sample start
// Notes:   register port driven right after rising edges

`timescale 1ns/1ns

module tb;
  import acl_pkg::*;
  logic                    i_clk_sys = 1'b0;
  logic                    i_reset   = 1'b1;
  logic                    i_clk_en  = 1'b1;
  logic [ACL_ADDR_W-1:0]   i_addr    = '0;
  logic [ACL_DATA_W-1:0]   i_wdata   = '0;
  logic                    i_wr      = 1'b0;
  logic                    i_rd      = 1'b0;
  logic [ACL_DATA_W-1:0]   o_rdata;
  logic o_regulator_force_zero, o_regulator_on, o_converter_enable;
  logic o_converter_reset, o_chopping_enable, o_midscale_sample;
  logic o_single_ended_select, o_sign_inversion, o_sample_start;
  logic o_done_irq, o_irq, i_sample_done;
  acl_chan_t               o_pos_channel, o_neg_channel;
  logic [ACL_SAMPLE_W-1:0] i_sample_data;
  logic [4:0]              core_delay = 5'h01;
  logic [1:0]              sgn = 2'b00;
  int miscompares = 0, total_checks = 0, pulses = 0;
  localparam logic [15:0] VAL = 16'h02a5;
  localparam logic [15:0] OFS = 16'h0004; // core model offset

  acl_top acl_top_i (.i_clk_sys, .i_reset, .i_clk_en, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_regulator_force_zero, .o_regulator_on,
    .o_converter_enable, .o_converter_reset, .o_chopping_enable,
    .o_midscale_sample, .o_single_ended_select, .o_sign_inversion,
    .o_sample_start, .o_pos_channel, .o_neg_channel, .i_sample_done,
    .i_sample_data, .o_done_irq, .o_irq);
  acl_core_model acl_core_model_i (.i_clk_sys, .i_reset,
    .i_start(o_sample_start), .i_sign(o_sign_inversion),
    .i_core_reset(o_converter_reset), .i_delay(core_delay),
    .o_done(i_sample_done), .o_data(i_sample_data));

  // ***************************************************
  // clock, pulse log and shared tasks
  // ***************************************************
  initial forever #5 i_clk_sys = ~i_clk_sys;
  // keeps the signs seen at the last two sample requests
  always @(posedge i_clk_sys) begin
    if (o_sample_start === 1'b1) begin
      sgn    <= {sgn[0], o_sign_inversion};
      pulses <= pulses + 1;
    end
  end
  task automatic cmp(input logic [15:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    #1 d = o_rdata; // data stands only in this cycle
  endtask
  task automatic rdc(input logic [31:0] a, input logic [15:0] e,
                     input string m);
    logic [15:0] v;
    rd(a, v);
    cmp(v, e, m);
  endtask
  // polls the start bit, bounded so a lost completion cannot hang
  task automatic wait_done();
    logic [15:0] v;
    v = 16'h0002;
    for (int n = 0; n < 40 && v[1] !== 1'b0; n++) rd(ACL_ADDR_CONTROL, v);
    cmp({15'h0, v[1]}, 16'h0, "start bit not cleared");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_fields();
    rdc(ACL_ADDR_CONTROL, 16'h0000, "control reset");
    rdc(ACL_ADDR_RESULT, 16'h0000, "result reset");
    @(posedge i_clk_sys);
    i_clk_en <= 1'b0; // frozen block takes no write
    wr(ACL_ADDR_CONTROL, 16'hc000);
    @(posedge i_clk_sys);
    i_clk_en <= 1'b1;
    rdc(ACL_ADDR_CONTROL, 16'h0000, "write taken while frozen");
    wr(ACL_ADDR_CONTROL, 16'hfff0); // done bit written too
    rdc(ACL_ADDR_CONTROL, 16'hffe0, "control read back");
    cmp({o_regulator_force_zero, o_regulator_on, o_chopping_enable,
         o_midscale_sample, o_single_ended_select, o_sign_inversion,
         o_converter_reset}, 16'h007f, "control outputs");
    wr(ACL_ADDR_CONTROL, 16'h0000);
    cmp({o_regulator_force_zero, o_regulator_on}, 16'h0, "regulator");
    rdc(32'h5000_1520, 16'h0000, "unmapped read");
  endtask
  task automatic t_route();
    acl_chan_t ep, en;
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 16; c++) begin
        wr(ACL_ADDR_CONTROL, 16'(m << 11) | 16'(c << 6));
        repeat (2) @(posedge i_clk_sys);
        #1;
        if (m == 1) begin
          ep = (c <= 9) ? acl_chan_t'(c) : ACL_CH_NONE;
          en = ACL_CH_NONE;
        end else begin
          ep = (c == 0) ? ACL_CH_P0_0 : ACL_CH_P0_2;
          en = (c == 0) ? ACL_CH_P0_1 : ACL_CH_P0_3;
        end
        cmp(16'(o_pos_channel), 16'(ep), "positive input");
        cmp(16'(o_neg_channel), 16'(en), "negative input");
      end
    end
    wr(ACL_ADDR_CONTROL, 16'h0400); // inverted differential pair 0/1
    repeat (2) @(posedge i_clk_sys);
    #1 cmp({o_pos_channel, o_neg_channel}, 16'h0010, "swap");
    wr(ACL_ADDR_CONTROL, 16'h1800);
    repeat (2) @(posedge i_clk_sys);
    #1 cmp({o_pos_channel, o_neg_channel}, 16'h00ee, "mute");
  endtask
  task automatic t_conv();
    wr(ACL_ADDR_CONTROL, 16'h0821); // selection before start
    wr(ACL_ADDR_CONTROL, 16'h0823);
    wait_done();
    rdc(ACL_ADDR_RESULT, VAL + OFS, "result");
    rdc(ACL_ADDR_CONTROL, 16'h0831, "done flag set");
    cmp({15'h0, o_done_irq}, 16'h1, "irq unmasked");
    wr(ACL_ADDR_CLEAR, 16'h0000);
    cmp({15'h0, o_done_irq}, 16'h0, "irq after clear");
    rdc(ACL_ADDR_CONTROL, 16'h0821, "flag after clear");
    core_delay <= 5'h0c; // slow core, inverted sign, masked
    wr(ACL_ADDR_CONTROL, 16'h0c03);
    wait_done();
    cmp({15'h0, o_done_irq}, 16'h0, "irq masked");
    rdc(ACL_ADDR_CONTROL, 16'h0c11, "masked flag");
    rdc(ACL_ADDR_RESULT, VAL - OFS, "inverted result");
    wr(ACL_ADDR_CLEAR, 16'h0000);
    wr(ACL_ADDR_MASK, 16'h0001);
    cmp({15'h0, o_irq}, 16'h1, "status irq");
    wr(ACL_ADDR_STATUS, 16'h0001);
    cmp({15'h0, o_irq}, 16'h0, "status cleared");
  endtask
  task automatic t_chop();
    int p0;
    p0 = pulses;
    wr(ACL_ADDR_CONTROL, 16'h2003);
    wait_done();
    cmp(16'(pulses - p0), 16'h2, "two samples");
    cmp({14'h0, sgn}, 16'h1, "opposite signs");
    rdc(ACL_ADDR_RESULT, VAL, "chopped result");
    wr(ACL_ADDR_CLEAR, 16'h0000);
  endtask
  task automatic t_refuse();
    int p0;
    p0 = pulses;
    wr(ACL_ADDR_STATUS, 16'h0003);
    wr(ACL_ADDR_CONTROL, 16'h0002); // start while disabled
    repeat (3) @(posedge i_clk_sys);
    cmp(16'(pulses - p0), 16'h0, "start while off");
    rdc(ACL_ADDR_STATUS, 16'h0002, "ignored start");
    wr(ACL_ADDR_MASK, 16'h0002);
    cmp({15'h0, o_irq}, 16'h1, "ignored irq");
    wr(ACL_ADDR_STATUS, 16'h0002);
    cmp({15'h0, o_irq}, 16'h0, "ignored cleared");
    wr(ACL_ADDR_CONTROL, 16'h0003); // abort mid-conversion
    wr(ACL_ADDR_CONTROL, 16'h0000);
    cmp({o_converter_enable, o_converter_reset}, 16'h1, "core off");
    repeat (30) @(posedge i_clk_sys);
    rdc(ACL_ADDR_CONTROL, 16'h0000, "abort leaves no done");
  endtask

  // ***************************************************
  // main sequence and watchdog
  // ***************************************************
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    t_fields();
    t_route();
    t_conv();
    t_chop();
    t_refuse();
    report_and_stop();
  end
  initial begin
    #300000;
    miscompares++;
    report_and_stop();
  end
endmodule // tb

bind acl_top acl_top_sva acl_top_sva_i (.i_clk_sys, .i_reset, .i_wr,
  .o_regulator_force_zero, .o_regulator_on, .o_converter_enable,
  .o_converter_reset, .o_chopping_enable, .o_midscale_sample,
  .o_single_ended_select, .o_sign_inversion, .o_sample_start,
  .o_pos_channel, .o_neg_channel, .o_done_irq);
